// ### logic/soft_power_consts.svh
// constants for the soft power status and wake block
`ifndef SOFT_POWER_CONSTS_SVH
`define SOFT_POWER_CONSTS_SVH
`define POWER_STATUS_LOW_OFFSET 8'h78
`define POWER_STATUS_HIGH_OFFSET 8'h79
`define POWER_STATUS_RESET 8'h00
`define BUTTON_PRESS_BIT 0
`define ALARM_BIT 2
`define BUTTON_OVERRIDE_BIT 3
`define WAKE_BIT 7
`define CLOCK_PERIOD_NS 50
`define OVERRIDE_HOLD_S 4
`define OVERRIDE_HOLD_CYCLES (`OVERRIDE_HOLD_S * (1000000000 / `CLOCK_PERIOD_NS))
`define DEBOUNCE_CYCLES 16
`endif

// ### logic/soft_power_pkg.sv
// types for the soft power status and wake block
package soft_power_pkg;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [1:0] {
    supply_off = 2'b00,
    supply_on = 2'b01
  } supply_state_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic button;
    logic [4:0] filt_cnt;
    logic [31:0] hold_cnt;
    logic held_done;
    logic button_press_flag;
    logic alarm_flag;
    logic button_override_flag;
    logic wake_flag;
    logic standby_prev;
    supply_state_type supply;
    logic wake_event_out_n;
    logic supply_on_out_n;
    logic supply_on_oe_n;
    logic [7:0] rdata;
  } state_type;
endpackage

// ### logic/soft_power_wake_status.sv
// soft power status flags, button override and wake control
//
// Functional notes
// - button press sets button press flag
// - wake event low while enable and flag
// - button wakes from soft-off regardless of enable
// - button flag cleared by write one
// - hold over four seconds: override, clear press
// - alarm sets alarm flag bit two
// - enabled alarm flag asserts wake event
// - enabled alarm wakes supply when off
// - remembered alarm sets flag without standby
// - standby return with alarm flag wakes when remember is enabled
// - alarm flag cleared by write one
// - override blocks alarm wakeup
// - low status register reads zero
// - high status resets zero; bit seven wake
// - override flag bit three, write one clears
// - under override only button wakes
`timescale 1ns/100ps
`default_nettype none
`include "soft_power_consts.svh"
module soft_power_wake_status #(
  parameter logic [31:0] HOLD_CYCLES = `OVERRIDE_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic standby_por,
  input wire soft_power_pkg::reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic power_button_in_n,
  input wire logic rtc_alarm,
  input wire logic standby_present,
  input wire logic button_event_enable,
  input wire logic alarm_event_enable,
  input wire logic alarm_remember_enable,
  input wire logic sleep_request,
  input wire logic wake_control,
  output logic wake_event_out_n,
  output logic supply_on_out_n,
  output logic supply_on_oe_n
);
  import soft_power_pkg::*;

  // state register and next state, then combinational decode and event strobes
  state_type s_q;
  state_type s_d;
  logic wr_high;
  logic rd_high;
  logic [7:0] clear_mask;
  logic [7:0] status_high;
  logic standby_return;
  logic alarm_seen;
  logic alarm_rise;
  logic alarm_replay;
  logic alarm_wake;
  logic button_edge;
  logic hold_expired;

  always_comb begin
    s_d = s_q;
    // register decode: only the high status register holds flags
    wr_high = reg_req.wr_en && (reg_req.addr == `POWER_STATUS_HIGH_OFFSET);
    rd_high = reg_req.rd_en && (reg_req.addr == `POWER_STATUS_HIGH_OFFSET);
    clear_mask = 8'h00;
    if (wr_high) begin
      clear_mask = reg_req.wdata;
    end

    // standby level edge, used to replay a remembered alarm
    standby_return = standby_present && !s_q.standby_prev;
    s_d.standby_prev = standby_present;

    // two stage sync, then a stable count before the filtered level moves
    // a glitch shorter than the count resets it and never reaches the flags
    s_d.sync1 = !power_button_in_n;
    s_d.sync2 = s_q.sync1;
    if (s_q.sync2 == s_q.button) begin
      s_d.filt_cnt = 5'h00;
    end else if (s_q.filt_cnt == 5'(`DEBOUNCE_CYCLES - 1)) begin
      s_d.button = s_q.sync2;
      s_d.filt_cnt = 5'h00;
    end else begin
      s_d.filt_cnt = s_q.filt_cnt + 5'h01;
    end
    button_edge = s_d.button && !s_q.button;

    // write one clears; the hardware sets further down win in the same cycle
    if (clear_mask[`BUTTON_PRESS_BIT]) begin
      s_d.button_press_flag = 1'b0;
    end
    if (clear_mask[`ALARM_BIT]) begin
      s_d.alarm_flag = 1'b0;
    end
    if (clear_mask[`BUTTON_OVERRIDE_BIT]) begin
      s_d.button_override_flag = 1'b0;
    end
    if (clear_mask[`WAKE_BIT]) begin
      s_d.wake_flag = 1'b0;
    end

    // press flag is set while the filtered level is high, until an override ends the press
    if (s_q.button && !s_q.held_done) begin
      s_d.button_press_flag = 1'b1;
    end

    // hold timer; one override per press, held_done stays set until released
    // the counter stops at the limit, so a very long press cannot wrap it
    hold_expired = s_q.button && !s_q.held_done && (s_q.hold_cnt >= HOLD_CYCLES);
    if (!s_q.button) begin
      s_d.hold_cnt = 32'h0;
      s_d.held_done = 1'b0;
    end else if (hold_expired) begin
      s_d.held_done = 1'b1;
    end else if (!s_q.held_done) begin
      s_d.hold_cnt = s_q.hold_cnt + 32'h1;
    end
    if (hold_expired) begin
      s_d.button_press_flag = 1'b0;
      s_d.button_override_flag = 1'b1;
    end

    // an alarm without standby is only kept when remember is enabled
    alarm_seen = rtc_alarm && (standby_present || alarm_remember_enable);
    if (alarm_seen) begin
      s_d.alarm_flag = 1'b1;
    end
    alarm_rise = s_d.alarm_flag && !s_q.alarm_flag;

    // a remembered alarm is replayed once, when standby power comes back
    alarm_replay = standby_return && s_q.alarm_flag && alarm_remember_enable;

    // an override blocks every wake source except the button itself
    alarm_wake = 1'b0;
    if (!s_q.button_override_flag) begin
      if (alarm_event_enable && alarm_rise) begin
        alarm_wake = 1'b1;
      end
      if (alarm_replay) begin
        alarm_wake = 1'b1;
      end
    end

    // supply state; an alarm wake from off needs standby power behind it
    unique case (s_q.supply)
      supply_off: begin
        if (button_edge) begin
          s_d.supply = supply_on;
          s_d.wake_flag = s_d.wake_flag || wake_control;
        end else if (alarm_wake && standby_present) begin
          s_d.supply = supply_on;
          s_d.wake_flag = s_d.wake_flag || wake_control;
        end
      end
      supply_on: begin
        if (sleep_request && !button_edge) begin
          s_d.supply = supply_off;
        end
      end
      // codes beyond the two states fall back to soft-off
      default: begin
        s_d.supply = supply_off;
      end
    endcase
    // the override wins over any other supply request
    if (hold_expired) begin
      s_d.supply = supply_off;
    end

    // wake event is a level: it stays low while an enabled press flag, or an enabled alarm flag without override, is up
    s_d.wake_event_out_n = 1'b1;
    if (button_event_enable && s_d.button_press_flag) begin
      s_d.wake_event_out_n = 1'b0;
    end
    if (alarm_event_enable && s_d.alarm_flag && !s_d.button_override_flag) begin
      s_d.wake_event_out_n = 1'b0;
    end

    // supply-on only ever pulls low; floating it is what turns power off
    s_d.supply_on_out_n = 1'b0;
    s_d.supply_on_oe_n = (s_d.supply != supply_on);

    // flag image of the high status register; holes stay zero
    status_high = 8'h00;
    status_high[`BUTTON_PRESS_BIT] = s_q.button_press_flag;
    status_high[`ALARM_BIT] = s_q.alarm_flag;
    status_high[`BUTTON_OVERRIDE_BIT] = s_q.button_override_flag;
    status_high[`WAKE_BIT] = s_q.wake_flag;

    // read data stands one cycle; the low register and holes read zero
    s_d.rdata = 8'h00;
    if (rd_high) begin
      s_d.rdata = status_high;
    end

    // the standby power-on reset only touches the wake bit
    if (standby_por) begin
      s_d.wake_flag = 1'b0;
    end
  end

  // one register for the whole state; reset leaves the supply floating
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
      s_q.wake_event_out_n <= 1'b1;
      s_q.supply_on_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata = s_q.rdata;
  assign wake_event_out_n = s_q.wake_event_out_n;
  assign supply_on_out_n = s_q.supply_on_out_n;
  assign supply_on_oe_n = s_q.supply_on_oe_n;
endmodule
`default_nettype wire

// ### testbench/soft_power_wake_status_chk.sv
// port assertions for the soft power block
`timescale 1ns/100ps
`default_nettype none
module soft_power_wake_status_chk #(parameter logic [31:0] HOLD_CYCLES = 32'h64) (
  input wire logic mclk,
  input wire logic srst,
  input wire soft_power_pkg::reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic power_button_in_n,
  input wire logic standby_present,
  input wire logic alarm_event_enable,
  input wire logic alarm_remember_enable,
  input wire logic button_event_enable,
  input wire logic wake_event_out_n,
  input wire logic supply_on_out_n,
  input wire logic supply_on_oe_n
);
  import soft_power_pkg::*;
  logic [31:0] low_q;
  // run length of the raw press, saturating so it never wraps to zero
  always_ff @(posedge mclk) low_q <= power_button_in_n ? 32'h0 : low_q + 32'(low_q != 32'hFFFFFFFF);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_unmapped_zero: assert property (reg_req.rd_en && reg_req.addr != 8'h79 |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_idle_rdata: assert property (!reg_req.rd_en |=> reg_rdata == 8'h00)
    else $error("read data without read");
  a_drive_low: assert property (supply_on_out_n == 1'b0)
    else $error("supply line driven high");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> wake_event_out_n && supply_on_oe_n)
    else $error("outputs active after reset");
  a_no_enable_quiet: assert property (!button_event_enable && !alarm_event_enable |=> wake_event_out_n)
    else $error("wake event without enable");
  a_alarm_wake_cause: assert property ($fell(supply_on_oe_n) && power_button_in_n |->
    standby_present && ($past(alarm_event_enable) || alarm_remember_enable))
    else $error("wakeup without cause");
  a_debounced_wake: assert property ($fell(supply_on_oe_n) && !power_button_in_n |-> low_q > 32'hF)
    else $error("button wake before filter");
  a_override_float: assert property (low_q > HOLD_CYCLES + 32'h28 |-> supply_on_oe_n)
    else $error("supply driven after long hold");
endmodule
`default_nettype wire

// ### testbench/soft_power_partner.sv
// button and supply model on the far side of the soft power block
`timescale 1ns/100ps
`default_nettype none
module soft_power_partner (
  input wire logic supply_on_out_n,
  input wire logic supply_on_oe_n,
  input wire logic press,
  output logic power_button_in_n,
  output logic supply_up
);
  // the supply pulls its input up, so a floating line means off
  assign supply_up = !(supply_on_oe_n ? 1'b1 : supply_on_out_n);
  assign power_button_in_n = !press;
endmodule
`default_nettype wire

// ### testbench/soft_power_wake_status_tb.sv
// self-checking bench for the soft power block
`timescale 1ns/100ps
`default_nettype none
module soft_power_wake_status_tb;
  import soft_power_pkg::*;
  localparam logic [31:0] HOLD_CYCLES = 32'h64;
  logic mclk, srst, press, up, btn_n, wk_n, son_n, oe_n, alarm, stby, ben, aen, rem, sleep;
  logic wctl, spor;
  logic [7:0] rdata;
  reg_req_type rq;
  int err_total, compares;
  soft_power_wake_status #(.HOLD_CYCLES(HOLD_CYCLES)) dut (.mclk(mclk), .srst(srst),
    .standby_por(spor), .reg_req(rq), .reg_rdata(rdata), .power_button_in_n(btn_n),
    .rtc_alarm(alarm), .standby_present(stby), .button_event_enable(ben),
    .alarm_event_enable(aen), .alarm_remember_enable(rem), .sleep_request(sleep),
    .wake_control(wctl), .wake_event_out_n(wk_n), .supply_on_out_n(son_n), .supply_on_oe_n(oe_n));
  soft_power_partner far (.supply_on_out_n(son_n), .supply_on_oe_n(oe_n), .press(press),
    .power_button_in_n(btn_n), .supply_up(up));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk) rq <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) rq <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk) rq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) rq <= '0;
    @(negedge mclk);
    chk("status", e, rdata);
    @(posedge mclk);
  endtask
  // one-cycle pulse on sleep (w high) or alarm (w low), then let it settle
  task automatic pulse(logic w);
    cyc(1);
    if (w) sleep <= 1'b1;
    else alarm <= 1'b1;
    cyc(1);
    sleep <= 1'b0;
    alarm <= 1'b0;
    cyc(3);
  endtask
  task automatic t_regs();
    rd(8'h79, 8'h00);
    wr(8'h78, 8'hFF);
    rd(8'h78, 8'h00);
    rd(8'h7A, 8'h00);
  endtask
  task automatic t_button();
    press <= 1'b1;
    cyc(30);
    press <= 1'b0;
    cyc(25);
    chk("supply", 8'h01, 8'(up));
    chk("wake", 8'h01, 8'(wk_n));
    ben <= 1'b1;
    rd(8'h79, 8'h01);
    chk("wake", 8'h00, 8'(wk_n));
    wr(8'h79, 8'h00);
    rd(8'h79, 8'h01);
    wr(8'h79, 8'h01);
    rd(8'h79, 8'h00);
    chk("wake", 8'h01, 8'(wk_n));
  endtask
  task automatic t_alarm();
    aen <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    chk("supply", 8'h01, 8'(up));
    chk("wake", 8'h00, 8'(wk_n));
    rd(8'h79, 8'h04);
    wr(8'h79, 8'h04);
    rd(8'h79, 8'h00);
  endtask
  task automatic t_remember();
    pulse(1'b1);
    stby <= 1'b0;
    rem <= 1'b1;
    pulse(1'b0);
    rd(8'h79, 8'h04);
    stby <= 1'b1;
    cyc(3);
    chk("supply", 8'h01, 8'(up));
    wr(8'h79, 8'h04);
  endtask
  task automatic t_override();
    press <= 1'b1;
    cyc(HOLD_CYCLES + 60);
    chk("supply", 8'h00, 8'(up));
    rd(8'h79, 8'h08);
    press <= 1'b0;
    cyc(25);
    pulse(1'b0);
    chk("supply", 8'h00, 8'(up));
    rd(8'h79, 8'h0C);
    wr(8'h79, 8'h00);
    rd(8'h79, 8'h0C);
    wr(8'h79, 8'h0C);
    rd(8'h79, 8'h00);
  endtask
  // wake bit set by an alarm wake, then dropped by the standby power-on reset
  task automatic t_wakebit();
    wctl <= 1'b1;
    pulse(1'b1);
    pulse(1'b0);
    chk("supply", 8'h01, 8'(up));
    rd(8'h79, 8'h84);
    spor <= 1'b1;
    cyc(1);
    spor <= 1'b0;
    rd(8'h79, 8'h04);
    wr(8'h79, 8'h84);
    rd(8'h79, 8'h00);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    {srst, press, alarm, stby, ben, aen, rem, sleep, wctl, spor} = 10'h240;
    rq = '0;
    cyc(6);
    srst <= 1'b0;
    t_regs();
    t_button();
    t_alarm();
    t_remember();
    t_override();
    t_wakebit();
    summarize();
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    #250000;
    err_total++;
    summarize();
  end
endmodule
bind soft_power_wake_status soft_power_wake_status_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);
`default_nettype wire
